//--- rtl/exc_pkg.sv
// Constants for the reset-vector and mode-select block: vectors, source
// table, register map and field positions.
// Assumes a 16-bit vector space and a word-wide register slave.
`default_nettype none
package exc_pkg;
  // Fixed reset vectors
  localparam logic [15:0] VEC_HARD = 16'hFFFE;
  localparam logic [15:0] VEC_CMON = 16'hFFFC;
  localparam logic [15:0] VEC_WDOG = 16'hFFFA;

  // Interrupt sources, index 0 has the highest default priority
  localparam int NUM_SRC = 27;
  localparam int SRC_IDX_W = 5;
  localparam int SRC_TRAP = 0;
  localparam int SRC_SWI = 1;
  localparam int SRC_XIRQ = 2;
  localparam int SRC_IRQ = 3;
  localparam int SRC_RTI = 4;
  localparam int SRC_T0_CH = 5;
  localparam int SRC_T0_OVF = 13;
  localparam int SRC_T1_CH = 16;
  localparam int SRC_T1_OVF = 24;
  localparam int NUM_CH = 8;
  localparam logic [7:0] VEC_OFFSET [NUM_SRC] = '{
    8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hF0,
    8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0,
    8'hDE, 8'hDC, 8'hDA,
    8'hAE, 8'hAC, 8'hAA, 8'hA8, 8'hA6, 8'hA4, 8'hA2, 8'hA0,
    8'h9E, 8'h9C, 8'h9A};

  // Register byte addresses
  localparam int ADDR_W = 6;
  localparam logic [5:0] REG_MODE = 6'h00;
  localparam logic [5:0] REG_VBASE = 6'h04;
  localparam logic [5:0] REG_FREEZE = 6'h08;
  localparam logic [5:0] REG_OSC_CFG = 6'h0C;
  localparam logic [5:0] REG_WDOG_CTRL = 6'h10;
  localparam logic [5:0] REG_TIMER_IE = 6'h14;
  localparam logic [5:0] REG_STATUS = 6'h18;
  localparam logic [5:0] REG_MASK = 6'h1C;
  localparam logic [5:0] REG_PENDING = 6'h20;

  // Reset values and fields
  localparam logic [7:0] VBASE_RESET = 8'hFF;
  localparam logic MODE_NORMAL = 1'b1;
  localparam logic MODE_SPECIAL = 1'b0;
  localparam logic OSC_EN_RESET = 1'b0;
  localparam logic [2:0] WDOG_OFF = 3'h0;
  localparam int T1_IE_LSB = 8;
  localparam int NUM_EV = 4;
  localparam int EV_DISPATCH = 0;
  localparam int EV_CMON = 1;
  localparam int EV_WDOG = 2;
  localparam int EV_MODE = 3;
  localparam int PEND_ANY_BIT = 8;

  typedef enum logic [0:0] {disp_idle, disp_offer} disp_state_t;
endpackage
`default_nettype wire

//--- rtl/exc_prio_pick.sv
// Fixed-priority picker: lowest set index wins.
// Assumes requests are already masked and gated by the caller.
`default_nettype none
module exc_prio_pick #(
  parameter int WIDTH = 27,
  parameter int IDX_W = 5
) (
  input wire logic [WIDTH-1:0] req,
  output logic any,
  output logic [IDX_W-1:0] idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    // Walk from lowest priority up so the highest one is written last
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/exc_vector_unit.sv
// Reset vectoring, operating-mode select and prioritised interrupt vectors.
// Assumes a processor core that answers irq_req with a one-cycle irq_ack,
// and a clock/reset unit that holds the cause levels through reset.
`default_nettype none
module exc_vector_unit (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic mode_select_input,
  input wire logic cause_power_on,
  input wire logic cause_low_voltage,
  input wire logic cause_pin,
  input wire logic cause_illegal_addr,
  input wire logic cause_clock_monitor,
  input wire logic cause_watchdog,
  input wire logic clock_monitor_fail,
  input wire logic watchdog_timeout,
  input wire logic ccr_i_mask,
  input wire logic ccr_x_mask,
  input wire logic trap_req,
  input wire logic swi_req,
  input wire logic xirq_req,
  input wire logic irq_pin_req,
  input wire logic rti_req,
  input wire logic [7:0] first_timer_ch_req,
  input wire logic [2:0] first_timer_ovf_req,
  input wire logic [7:0] second_timer_ch_req,
  input wire logic [2:0] second_timer_ovf_req,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [15:0] reset_vector,
  output logic reset_vector_valid,
  output logic normal_mode,
  output logic debug_active,
  output logic [7:0] freeze,
  output logic cmon_reset_req,
  output logic wdog_reset_req
);
  logic in_reset;
  logic [7:0] vector_base_register;
  logic [7:0] freeze_enable;
  logic oscillator_enable_bit;
  logic [2:0] watchdog_rate_bits;
  logic [15:0] timer_irq_enable;
  logic [exc_pkg::NUM_EV-1:0] status;
  logic [exc_pkg::NUM_EV-1:0] mask;
  logic [exc_pkg::NUM_EV-1:0] events;
  logic [exc_pkg::NUM_EV-1:0] next_status;
  logic [exc_pkg::NUM_SRC-1:0] raw_req;
  logic [exc_pkg::NUM_SRC-1:0] eligible;
  logic [exc_pkg::SRC_IDX_W-1:0] win_idx;
  logic win_any;
  logic next_mode;
  logic mode_write_ok;
  logic do_write;
  logic [31:0] be_mask;
  logic [31:0] wdata;
  logic [31:0] next_readdata;
  logic hard_cause;
  logic cmon_gated;
  logic wdog_gated;
  exc_pkg::disp_state_t disp_state;

  // Register bus: one wait cycle, then the access completes
  assign do_write = avs_write && !avs_waitrequest;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata = avs_writedata & be_mask;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      exc_pkg::REG_MODE: next_readdata[0] = normal_mode;
      exc_pkg::REG_VBASE: next_readdata[7:0] = vector_base_register;
      exc_pkg::REG_FREEZE: next_readdata[7:0] = freeze_enable;
      exc_pkg::REG_OSC_CFG: next_readdata[0] = oscillator_enable_bit;
      exc_pkg::REG_WDOG_CTRL: next_readdata[2:0] = watchdog_rate_bits;
      exc_pkg::REG_TIMER_IE: next_readdata[15:0] = timer_irq_enable;
      exc_pkg::REG_STATUS: next_readdata[exc_pkg::NUM_EV-1:0] = status;
      exc_pkg::REG_MASK: next_readdata[exc_pkg::NUM_EV-1:0] = mask;
      exc_pkg::REG_PENDING: begin
        next_readdata[7:0] = exc_pkg::VEC_OFFSET[win_idx];
        next_readdata[exc_pkg::PEND_ANY_BIT] = win_any;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // Plain control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vector_base_register <= exc_pkg::VBASE_RESET;
      freeze_enable <= 8'h00;
      oscillator_enable_bit <= exc_pkg::OSC_EN_RESET;
      watchdog_rate_bits <= exc_pkg::WDOG_OFF;
      timer_irq_enable <= 16'h0000;
      mask <= '0;
    end else if (do_write) begin
      case (avs_address)
        exc_pkg::REG_VBASE: begin
          if (avs_byteenable[0]) vector_base_register <= wdata[7:0];
        end
        exc_pkg::REG_FREEZE: begin
          if (avs_byteenable[0]) freeze_enable <= wdata[7:0];
        end
        exc_pkg::REG_OSC_CFG: begin
          if (avs_byteenable[0]) oscillator_enable_bit <= wdata[0];
        end
        exc_pkg::REG_WDOG_CTRL: begin
          if (avs_byteenable[0]) watchdog_rate_bits <= wdata[2:0];
        end
        exc_pkg::REG_TIMER_IE: begin
          timer_irq_enable <= (timer_irq_enable & ~be_mask[15:0]) | wdata[15:0];
        end
        exc_pkg::REG_MASK: begin
          if (avs_byteenable[0]) mask <= wdata[exc_pkg::NUM_EV-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Mode: strap caught at the first edge after reset release
  assign mode_write_ok = do_write && avs_byteenable[0] && (avs_address == exc_pkg::REG_MODE)
                         && (normal_mode == exc_pkg::MODE_SPECIAL) && wdata[0];

  always_comb begin
    next_mode = normal_mode;
    if (in_reset) begin
      next_mode = mode_select_input;
    end else if (mode_write_ok) begin
      // Only special to normal; going back would hand debug to a running app
      next_mode = exc_pkg::MODE_NORMAL;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_reset <= 1'b1;
      normal_mode <= exc_pkg::MODE_SPECIAL;
      debug_active <= 1'b0;
    end else begin
      in_reset <= 1'b0;
      normal_mode <= next_mode;
      debug_active <= (next_mode == exc_pkg::MODE_SPECIAL);
    end
  end

  // Freeze follows debug state one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      freeze <= 8'h00;
    end else begin
      freeze <= freeze_enable & {8{debug_active}};
    end
  end

  // Reset vector chosen at release from held causes
  assign hard_cause = cause_power_on || cause_low_voltage || cause_pin
                      || cause_illegal_addr;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_vector <= exc_pkg::VEC_HARD;
      reset_vector_valid <= 1'b0;
    end else if (in_reset) begin
      if (hard_cause) begin
        reset_vector <= exc_pkg::VEC_HARD;
      end else if (cause_clock_monitor) begin
        reset_vector <= exc_pkg::VEC_CMON;
      end else if (cause_watchdog) begin
        reset_vector <= exc_pkg::VEC_WDOG;
      end else begin
        reset_vector <= exc_pkg::VEC_HARD;
      end
      // Special mode runs the debug monitor instead of the vector
      reset_vector_valid <= (mode_select_input == exc_pkg::MODE_NORMAL);
    end
  end

  // Local gating of the two soft reset sources
  assign cmon_gated = clock_monitor_fail && oscillator_enable_bit;
  assign wdog_gated = watchdog_timeout && (watchdog_rate_bits != exc_pkg::WDOG_OFF);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmon_reset_req <= 1'b0;
      wdog_reset_req <= 1'b0;
    end else begin
      cmon_reset_req <= cmon_gated;
      wdog_reset_req <= wdog_gated;
    end
  end

  // Source table in default priority order; overflow (bit2) leads its group
  assign raw_req = {second_timer_ovf_req[0], second_timer_ovf_req[1], second_timer_ovf_req[2],
                    second_timer_ch_req, first_timer_ovf_req[0], first_timer_ovf_req[1],
                    first_timer_ovf_req[2], first_timer_ch_req,
                    rti_req, irq_pin_req, xirq_req, swi_req, trap_req};

  always_comb begin
    eligible = raw_req;
    eligible[exc_pkg::SRC_XIRQ] = raw_req[exc_pkg::SRC_XIRQ] && !ccr_x_mask;
    for (int i = exc_pkg::SRC_IRQ; i < exc_pkg::NUM_SRC; i++) begin
      eligible[i] = raw_req[i] && !ccr_i_mask;
    end
    for (int c = 0; c < exc_pkg::NUM_CH; c++) begin
      eligible[exc_pkg::SRC_T0_CH + c] = eligible[exc_pkg::SRC_T0_CH + c]
                                         && timer_irq_enable[c];
      eligible[exc_pkg::SRC_T1_CH + c] = eligible[exc_pkg::SRC_T1_CH + c]
                                         && timer_irq_enable[exc_pkg::T1_IE_LSB + c];
    end
  end

  exc_prio_pick #(
    .WIDTH(exc_pkg::NUM_SRC),
    .IDX_W(exc_pkg::SRC_IDX_W)
  ) u_pick (
    .req(eligible),
    .any(win_any),
    .idx(win_idx)
  );

  // Offer stays live: a higher request arriving while offered replaces it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      disp_state <= exc_pkg::disp_idle;
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
    end else begin
      case (disp_state)
        exc_pkg::disp_idle: begin
          if (win_any) begin
            disp_state <= exc_pkg::disp_offer;
            irq_req <= 1'b1;
            irq_vector <= {vector_base_register, exc_pkg::VEC_OFFSET[win_idx]};
          end
        end
        exc_pkg::disp_offer: begin
          if (irq_ack || !win_any) begin
            disp_state <= exc_pkg::disp_idle;
            irq_req <= 1'b0;
          end else begin
            irq_vector <= {vector_base_register, exc_pkg::VEC_OFFSET[win_idx]};
          end
        end
        default: begin
          disp_state <= exc_pkg::disp_idle;
          irq_req <= 1'b0;
        end
      endcase
    end
  end

  // Sticky events, write one to clear, a new event beats the clear
  always_comb begin
    events = '0;
    events[exc_pkg::EV_DISPATCH] = irq_req && irq_ack;
    events[exc_pkg::EV_CMON] = cmon_gated;
    events[exc_pkg::EV_WDOG] = wdog_gated;
    events[exc_pkg::EV_MODE] = mode_write_ok;
    next_status = status;
    if (do_write && avs_byteenable[0] && (avs_address == exc_pkg::REG_STATUS)) begin
      next_status = status & ~wdata[exc_pkg::NUM_EV-1:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask);
    end
  end

  // Checks
  sequence s_release;
    in_reset && !rst;
  endsequence

  property p_mode_capture;
    @(posedge core_clk) disable iff (rst)
      s_release |=> (normal_mode == $past(mode_select_input));
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("mode not captured");

  property p_debug_special;
    @(posedge core_clk) disable iff (rst)
      !in_reset |-> (debug_active == (normal_mode == exc_pkg::MODE_SPECIAL));
  endproperty
  a_debug_special: assert property (p_debug_special) else $error("debug state wrong");

  property p_mode_oneway;
    @(posedge core_clk) disable iff (rst)
      (!in_reset && normal_mode) |=> normal_mode;
  endproperty
  a_mode_oneway: assert property (p_mode_oneway) else $error("left normal mode");

  property p_boot_vector;
    @(posedge core_clk) disable iff (rst)
      s_release |=> (reset_vector_valid == normal_mode);
  endproperty
  a_boot_vector: assert property (p_boot_vector) else $error("boot vector flag wrong");

  property p_freeze_debug;
    @(posedge core_clk) disable iff (rst)
      (freeze != 8'h00) |-> $past(debug_active);
  endproperty
  a_freeze_debug: assert property (p_freeze_debug) else $error("freeze outside debug");

  property p_hard_vec;
    @(posedge core_clk) disable iff (rst)
      (s_release and hard_cause) |=> (reset_vector == exc_pkg::VEC_HARD);
  endproperty
  a_hard_vec: assert property (p_hard_vec) else $error("hard reset vector wrong");

  property p_cmon_gate;
    @(posedge core_clk) disable iff (rst)
      (clock_monitor_fail && !oscillator_enable_bit) |=> !cmon_reset_req;
  endproperty
  a_cmon_gate: assert property (p_cmon_gate) else $error("clock monitor not gated");

  property p_wdog_gate;
    @(posedge core_clk) disable iff (rst)
      watchdog_timeout && (watchdog_rate_bits != exc_pkg::WDOG_OFF) |=> wdog_reset_req;
  endproperty
  a_wdog_gate: assert property (p_wdog_gate) else $error("watchdog reset lost");

  property p_vec_base;
    @(posedge core_clk) disable iff (rst)
      $rose(irq_req) |-> (irq_vector[15:8] == $past(vector_base_register));
  endproperty
  a_vec_base: assert property (p_vec_base) else $error("vector base not applied");

  property p_trap_first;
    @(posedge core_clk) disable iff (rst)
      (trap_req && !irq_ack) |=>
        (irq_req && irq_vector[7:0] == exc_pkg::VEC_OFFSET[exc_pkg::SRC_TRAP]);
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("trap not top priority");

  property p_t0_gate;
    @(posedge core_clk) disable iff (rst)
      (irq_req && irq_vector[7:0] == exc_pkg::VEC_OFFSET[exc_pkg::SRC_T0_CH])
        |-> $past(timer_irq_enable[0]) && !$past(ccr_i_mask);
  endproperty
  a_t0_gate: assert property (p_t0_gate) else $error("timer0 ch0 ungated");

  property p_t1_gate;
    @(posedge core_clk) disable iff (rst)
      (irq_req && irq_vector[7:0] == exc_pkg::VEC_OFFSET[exc_pkg::SRC_T1_CH])
        |-> $past(timer_irq_enable[exc_pkg::T1_IE_LSB]);
  endproperty
  a_t1_gate: assert property (p_t1_gate) else $error("timer1 ch0 ungated");

  property p_ovf_imask;
    @(posedge core_clk) disable iff (rst)
      (irq_req && (irq_vector[7:0] == exc_pkg::VEC_OFFSET[exc_pkg::SRC_T0_OVF]
                   || irq_vector[7:0] == exc_pkg::VEC_OFFSET[exc_pkg::SRC_T1_OVF]))
        |-> !$past(ccr_i_mask);
  endproperty
  a_ovf_imask: assert property (p_ovf_imask) else $error("overflow not I masked");

  property p_highest;
    @(posedge core_clk) disable iff (rst)
      (win_any && !irq_ack) |=> irq_req && (irq_vector[7:0] == exc_pkg::VEC_OFFSET[$past(win_idx)]);
  endproperty
  a_highest: assert property (p_highest) else $error("not highest vector");
endmodule
`default_nettype wire

//--- verif/core_model.sv
// Processor core stand-in: takes each offered vector after a set delay.
// Assumes the vector unit holds irq_req until it samples irq_ack.
`default_nettype none
module core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] ack_delay,
  output logic irq_ack,
  output logic [15:0] taken_vector,
  output logic [15:0] taken_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;

  // Ack only while an offer stands, never two cycles running
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_req && !irq_ack && wait_cnt >= ack_delay) begin
      irq_ack <= 1'b1;
      wait_cnt <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      wait_cnt <= (irq_req && !irq_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end

  // The vector counts as fetched at the edge where the ack is seen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      taken_vector <= 16'h0000;
      taken_count <= 16'h0000;
    end else if (irq_ack && irq_req) begin
      taken_vector <= irq_vector;
      taken_count <= taken_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the vector and mode unit.
// Assumes the register map and bus timing given with the design.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, irq, mode_select_input;
  logic [5:0] avs_address, cause;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, ack_delay;
  logic clock_monitor_fail, watchdog_timeout, ccr_i_mask, ccr_x_mask, irq_ack, irq_req;
  logic reset_vector_valid, normal_mode, debug_active, cmon_reset_req, wdog_reset_req;
  logic [26:0] req;
  logic [15:0] irq_vector, reset_vector, taken_vector, taken_count, base_cnt;
  logic [7:0] freeze;
  int err_count, cmp_count, cycles;
  logic [5:0] ra [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h3C};
  logic [31:0] rv [9] = '{32'h1, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [5:0] rc [7] = '{6'h02, 6'h01, 6'h03, 6'h23, 6'h11, 6'h0A, 6'h07};
  logic [15:0] rx [7] = '{16'hFFFC, 16'hFFFA, 16'hFFFC, 16'hFFFE, 16'hFFFE, 16'hFFFE, 16'hFFFE};

  exc_vector_unit dut_u (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .mode_select_input(mode_select_input),
    .cause_power_on(cause[5]), .cause_low_voltage(cause[4]), .cause_pin(cause[3]),
    .cause_illegal_addr(cause[2]), .cause_clock_monitor(cause[1]),
    .cause_watchdog(cause[0]), .clock_monitor_fail(clock_monitor_fail),
    .watchdog_timeout(watchdog_timeout), .ccr_i_mask(ccr_i_mask), .ccr_x_mask(ccr_x_mask),
    .trap_req(req[0]), .swi_req(req[1]), .xirq_req(req[2]), .irq_pin_req(req[3]),
    .rti_req(req[4]), .first_timer_ch_req(req[12:5]),
    .first_timer_ovf_req({req[13], req[14], req[15]}), .second_timer_ch_req(req[23:16]),
    .second_timer_ovf_req({req[24], req[25], req[26]}), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vector(irq_vector), .reset_vector(reset_vector),
    .reset_vector_valid(reset_vector_valid), .normal_mode(normal_mode),
    .debug_active(debug_active), .freeze(freeze), .cmon_reset_req(cmon_reset_req),
    .wdog_reset_req(wdog_reset_req));

  core_model core_u (.core_clk(core_clk), .rst(rst), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_delay(ack_delay), .irq_ack(irq_ack),
    .taken_vector(taken_vector), .taken_count(taken_count));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 3000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h timeout", $time, cycles, 20000);
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Slave registers its answer: one wait cycle per access
    check(32'(n), 32'h2);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask

  // Causes stay up past release, as the reset unit holds them
  task automatic do_reset(input logic m, input logic [5:0] c, input int n);
    @(posedge core_clk);
    rst <= 1'b1;
    mode_select_input <= m;
    cause <= c;
    repeat (n) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    cause <= 6'h00;
    @(posedge core_clk);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  function automatic logic [7:0] exp_off(input int i);
    if (i < 5) return 8'hF8 - 8'(2 * i);
    if (i < 13) return 8'hEE - 8'(2 * (i - 5));
    if (i < 16) return 8'hDE - 8'(2 * (i - 13));
    if (i < 24) return 8'hAE - 8'(2 * (i - 16));
    return 8'h9E - 8'(2 * (i - 24));
  endfunction

  initial begin
    rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    mode_select_input = 1'b1;
    cause = 6'h00;
    clock_monitor_fail = 1'b0;
    watchdog_timeout = 1'b0;
    ccr_i_mask = 1'b0;
    ccr_x_mask = 1'b0;
    req = 27'h0;
    ack_delay = 4'h0;
    do_reset(1'b1, 6'h00, 19);
    check({16'h0, reset_vector}, 32'hFFFE);
    check({31'h0, reset_vector_valid}, 32'h1);
    for (int i = 0; i < 9; i++) rdc(ra[i], 32'hFFFF_FFFF, rv[i]);
    bus(1'b1, 6'h3C, 32'hFF);
    rdc(6'h3C, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, 6'h00, 32'h0);
    rdc(6'h00, 32'h1, 32'h1);
    bus(1'b1, 6'h08, 32'hA5);
    wait_cyc(2);
    check({24'h0, freeze}, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      do_reset(i[0], rc[i], 3);
      check({31'h0, normal_mode}, {31'h0, i[0]});
      check({31'h0, debug_active}, {31'h0, !i[0]});
      check({16'h0, reset_vector}, {16'h0, rx[i]});
      check({31'h0, reset_vector_valid}, {31'h0, i[0]});
      rdc(6'h00, 32'h1, {31'h0, i[0]});
    end
    $display("test reset sources done");
    do_reset(1'b0, 6'h00, 3);
    bus(1'b1, 6'h08, 32'h5A);
    wait_cyc(2);
    check({24'h0, freeze}, 32'h5A);
    bus(1'b1, 6'h00, 32'h1);
    wait_cyc(2);
    check({31'h0, normal_mode}, 32'h1);
    check({24'h0, freeze}, 32'h0);
    rdc(6'h18, 32'hF, 32'h8);
    bus(1'b1, 6'h18, 32'hF);
    $display("test mode change done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, k[1] ? 6'h10 : 6'h0C, k[0] ? (k[1] ? 32'h3 : 32'h1) : 32'h0);
      @(posedge core_clk);
      clock_monitor_fail <= !k[1];
      watchdog_timeout <= k[1];
      @(posedge core_clk);
      clock_monitor_fail <= 1'b0;
      watchdog_timeout <= 1'b0;
      @(posedge core_clk);
      check({30'h0, wdog_reset_req, cmon_reset_req},
            {30'h0, k[0] & k[1], k[0] & !k[1]});
    end
    rdc(6'h18, 32'hF, 32'h6);
    bus(1'b1, 6'h1C, 32'h2);
    wait_cyc(3);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, 6'h18, 32'h2);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 6'h1C, 32'h4);
    wait_cyc(3);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, 6'h1C, 32'h0);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 6'h18, 32'hF);
    $display("test soft resets and irq done");
    bus(1'b1, 6'h04, 32'h12);
    bus(1'b1, 6'h14, 32'h0800);
    ack_delay <= 4'h3;
    ccr_x_mask <= 1'b1;
    req <= 27'h0FF1FE4;
    wait_cyc(6);
    rdc(6'h20, 32'h1FF, 32'h1A8);
    check({16'h0, taken_vector}, 32'h12A8);
    req <= 27'h0;
    bus(1'b1, 6'h14, 32'hFFFF);
    ccr_i_mask <= 1'b1;
    req <= 27'h700E018;
    wait_cyc(6);
    rdc(6'h20, 32'h100, 32'h0);
    ccr_i_mask <= 1'b0;
    wait_cyc(3);
    rdc(6'h20, 32'h1FF, 32'h1F2);
    $display("test gating done");
    req <= 27'h0;
    ccr_x_mask <= 1'b0;
    wait_cyc(4);
    req <= 27'h7FFFFFF;
    for (int i = 0; i < 27; i++) begin
      int n;
      ack_delay <= 4'(i % 3);
      base_cnt = taken_count;
      n = 0;
      while (taken_count === base_cnt && n < 100) begin
        @(posedge core_clk);
        n++;
      end
      check({16'h0, taken_vector}, {16'h0, 8'h12, exp_off(i)});
      req[i] <= 1'b0;
      wait_cyc(4);
    end
    rdc(6'h18, 32'h1, 32'h1);
    $display("test priority order done");
    stop_test();
  end
endmodule
`default_nettype wire
